// >>> cabinet_model.sv
// Purpose: Line power stand-in for the supervision block
// Assumes: Called from the bench just after a rising edge
// Notes: Level changes land by non-blocking assignment
`timescale 1ns/1ns
`default_nettype none
module cabinet_model (
    input wire logic clk,
    output logic lineOk
);
    initial lineOk = 1'b1;
    task automatic power(input logic on, input int n);
        lineOk <= on;
        repeat (n) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// >>> power_hold_pkg.sv
// Purpose: Constants for the power interruption flash timer
// Assumes: 20 MHz clock, synchronous active high reset
// Notes: Times kept in their own units; cycle counts derived here
// What this block does
// RL1 - Drop fault relay after outage above 475 ms
// RL2 - Keep relay dropped for hold after return
// RL3 - Hold interval settable from 4 to 10 s
// RL4 - One second setting steps, repeatable timing
// RL5 - Restart relay to open contact 2.5 s
// RL6 - Restart relay back to closed contact after
// RL7 - Energize fault relay only when healthy
// RL8 - Latched conflict fault survives hold end
// RL9 - Extension connector absent changes nothing
// RL10 - Outage timer restarts; one shared time base
package power_hold_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int OUTAGE_MS = 475;
    localparam int OUTAGE_CYC = (CLK_HZ / 1000) * OUTAGE_MS;
    localparam int TICK_MS = 100;
    localparam int TICK_CYC = (CLK_HZ / 1000) * TICK_MS;
    localparam int RESTART_MS = 2500;
    localparam int RESTART_TICKS = RESTART_MS / TICK_MS;
    localparam int SEC_MS = 1000;
    localparam int TICKS_PER_SEC = SEC_MS / TICK_MS;
    localparam logic [3:0] HOLD_MIN_S = 4'h4;
    localparam logic [3:0] HOLD_MAX_S = 4'hA;
    localparam logic [3:0] HOLD_RST_S = 4'h4;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_OUT = 2'b01,
        ST_HOLD = 2'b11
    } phase_t;
endpackage

// >>> power_interrupt_flash_timer.sv
// Purpose: Power interruption supervision with flash hold and restart pulse
// Assumes: lineOk and extension inputs are asynchronous pins
// Notes: Restart pulse and hold both start at power return
`timescale 1ns/1ns
`default_nettype none
module power_interrupt_flash_timer #(
    parameter int OUTAGE_CYCLES = power_hold_pkg::OUTAGE_CYC,
    parameter int TICK_CYCLES = power_hold_pkg::TICK_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic lineOk,
    input wire logic [3:0] holdSeconds,
    input wire logic conflictFault,
    input wire logic voltagesOk,
    input wire logic extPresent,
    input wire logic extFault,
    output logic faultRelayOn,
    output logic restartRelayOn,
    output logic holdActive
);
    import power_hold_pkg::*;
    localparam logic [31:0] HOLD_MIN_CYC = 32'(int'(HOLD_MIN_S) * TICKS_PER_SEC * TICK_CYCLES);
    localparam logic [31:0] HOLD_MAX_CYC = 32'(int'(HOLD_MAX_S) * TICKS_PER_SEC * TICK_CYCLES);

    logic [1:0] lineSync_r;
    logic [1:0] extSync_r;
    logic [1:0] extFaultSync_r;
    phase_t phase_r, phase_nxt;
    logic [31:0] outCnt_r, outCnt_nxt;
    logic [31:0] tickCnt_r, tickCnt_nxt;
    logic tick;
    logic [7:0] holdTicks_r, holdTicks_nxt;
    logic [7:0] restartTicks_r, restartTicks_nxt;
    logic [7:0] holdTarget;
    logic [3:0] holdClamped;
    logic faultRelay_r, faultRelay_nxt;
    logic restart_r, restart_nxt;
    logic lineNow;
    logic extFaultEff;
    logic [31:0] holdCyc_r, holdCyc_nxt;

    always_ff @(posedge clk) begin
        if (srst) begin
            lineSync_r <= 2'h0;
            extSync_r <= 2'h0;
            extFaultSync_r <= 2'h0;
        end else begin
            lineSync_r <= {lineSync_r[0], lineOk};
            extSync_r <= {extSync_r[0], extPresent};
            extFaultSync_r <= {extFaultSync_r[0], extFault};
        end
    end
    assign lineNow = lineSync_r[1];
    // Extension fault only counts while its connector is plugged
    assign extFaultEff = extSync_r[1] & extFaultSync_r[1]; // RL9

    always_comb begin
        if (holdSeconds < HOLD_MIN_S) begin
            holdClamped = HOLD_MIN_S; // RL3
        end else if (holdSeconds > HOLD_MAX_S) begin
            holdClamped = HOLD_MAX_S; // RL3
        end else begin
            holdClamped = holdSeconds; // RL4
        end
        holdTarget = 8'(holdClamped) * 8'(TICKS_PER_SEC);
    end

    assign tick = (tickCnt_r == 32'(TICK_CYCLES - 1)); // RL10

    always_comb begin
        phase_nxt = phase_r;
        outCnt_nxt = outCnt_r;
        tickCnt_nxt = tick ? 32'h0 : tickCnt_r + 32'h1;
        holdTicks_nxt = holdTicks_r;
        restartTicks_nxt = restartTicks_r;
        restart_nxt = restart_r;
        if (restart_r && tick) begin
            if (restartTicks_r == 8'(RESTART_TICKS - 1)) begin
                restart_nxt = 1'b0; // RL6
                restartTicks_nxt = 8'h0;
            end else begin
                restartTicks_nxt = restartTicks_r + 8'h1;
            end
        end
        case (phase_r)
            ST_RUN: begin
                if (!lineNow) begin
                    if (outCnt_r == 32'(OUTAGE_CYCLES - 1)) begin
                        phase_nxt = ST_OUT; // RL1
                    end else begin
                        outCnt_nxt = outCnt_r + 32'h1;
                    end
                end else begin
                    outCnt_nxt = 32'h0; // RL10
                end
            end
            ST_OUT: begin
                outCnt_nxt = 32'h0;
                if (lineNow) begin
                    phase_nxt = ST_HOLD; // RL2
                    holdTicks_nxt = 8'h0;
                    tickCnt_nxt = 32'h0; // RL4
                    restart_nxt = 1'b1; // RL5
                    restartTicks_nxt = 8'h0;
                end
            end
            ST_HOLD: begin
                if (!lineNow) begin
                    phase_nxt = ST_RUN;
                    restart_nxt = 1'b0;
                    restartTicks_nxt = 8'h0;
                end else if (tick) begin
                    if (holdTicks_r + 8'h1 >= holdTarget) begin
                        phase_nxt = ST_RUN; // RL2
                    end else begin
                        holdTicks_nxt = holdTicks_r + 8'h1;
                    end
                end
            end
            default: phase_nxt = ST_RUN;
        endcase
        // Latched faults are outside; hold end never overrides them
        faultRelay_nxt = (phase_nxt == ST_RUN) && lineNow && voltagesOk
            && !conflictFault && !extFaultEff; // RL7 RL8
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            phase_r <= ST_RUN;
            outCnt_r <= 32'h0;
            tickCnt_r <= 32'h0;
            holdTicks_r <= 8'h0;
            restartTicks_r <= 8'h0;
            faultRelay_r <= 1'b0;
            restart_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            outCnt_r <= outCnt_nxt;
            tickCnt_r <= tickCnt_nxt;
            holdTicks_r <= holdTicks_nxt;
            restartTicks_r <= restartTicks_nxt;
            faultRelay_r <= faultRelay_nxt;
            restart_r <= restart_nxt;
        end
    end

    assign faultRelayOn = faultRelay_r;
    assign restartRelayOn = restart_r;
    assign holdActive = (phase_r != ST_RUN);

    // Cycles spent in hold, read by the checks only
    always_comb begin
        holdCyc_nxt = (phase_r == ST_HOLD) ? holdCyc_r + 32'h1 : 32'h0;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            holdCyc_r <= 32'h0;
        end else begin
            holdCyc_r <= holdCyc_nxt;
        end
    end

    // Relay gating
    chk_hold_drops_relay: assert property (@(posedge clk) disable iff (srst) // RL2
        (phase_r != ST_RUN) |-> !faultRelayOn)
        else $error("relay on during outage or hold");
    chk_conflict_blocks_relay: assert property (@(posedge clk) disable iff (srst) // RL8
        conflictFault |=> !faultRelayOn)
        else $error("relay on with conflict");
    chk_voltage_gate: assert property (@(posedge clk) disable iff (srst) // RL7
        !voltagesOk |=> !faultRelayOn)
        else $error("relay on with low voltage");
    chk_line_gate: assert property (@(posedge clk) disable iff (srst) // RL7
        !lineNow |=> !faultRelayOn)
        else $error("relay on without line power");
    chk_relay_rise_cause: assert property (@(posedge clk) disable iff (srst) // RL7
        $rose(faultRelayOn) |-> (phase_r == ST_RUN && $past(voltagesOk) && !$past(conflictFault)))
        else $error("relay rose while unhealthy");
    chk_ext_gate: assert property (@(posedge clk) disable iff (srst) // RL9
        (extSync_r[1] && extFaultSync_r[1]) |=> !faultRelayOn)
        else $error("ext fault ignored");
    chk_ext_unplugged: assert property (@(posedge clk) disable iff (srst) // RL9
        (!extSync_r[1] && lineNow && voltagesOk && !conflictFault && phase_nxt == ST_RUN) |=> faultRelayOn)
        else $error("unplugged extension blocked relay");
    // Outage detection and timer restart
    chk_outage_threshold: assert property (@(posedge clk) disable iff (srst) // RL1
        $rose(phase_r == ST_OUT) |-> ($past(outCnt_r) == 32'(OUTAGE_CYCLES - 1) && !$past(lineNow)))
        else $error("outage taken before threshold");
    chk_outage_counts: assert property (@(posedge clk) disable iff (srst) // RL10
        (phase_r == ST_RUN && lineNow) |=> outCnt_r == 32'h0)
        else $error("outage timer kept");
    chk_hold_outage_clear: assert property (@(posedge clk) disable iff (srst) // RL10
        (phase_r == ST_HOLD) |-> outCnt_r == 32'h0)
        else $error("outage timer not cleared in hold");
    chk_tick_bound: assert property (@(posedge clk) disable iff (srst) // RL10
        tickCnt_r <= 32'(TICK_CYCLES - 1))
        else $error("time base overran");
    // Hold timing
    chk_return_starts_hold: assert property (@(posedge clk) disable iff (srst) // RL2
        (phase_r == ST_OUT && lineNow) |=> phase_r == ST_HOLD)
        else $error("no hold after return");
    chk_hold_waits_tick: assert property (@(posedge clk) disable iff (srst) // RL4
        (phase_r == ST_HOLD && lineNow && !tick) |=> phase_r == ST_HOLD)
        else $error("hold ended between ticks");
    chk_hold_span: assert property (@(posedge clk) disable iff (srst) // RL3
        (phase_r == ST_HOLD && lineNow && phase_nxt == ST_RUN)
        |-> (holdCyc_r >= HOLD_MIN_CYC - 32'h1 && holdCyc_r <= HOLD_MAX_CYC - 32'h1))
        else $error("hold length outside range");
    chk_hold_limit: assert property (@(posedge clk) disable iff (srst) // RL3
        holdCyc_r <= HOLD_MAX_CYC)
        else $error("hold ran past maximum");
    chk_hold_range: assert property (@(posedge clk) disable iff (srst) // RL3
        holdTarget >= 8'h28 && holdTarget <= 8'h64)
        else $error("hold out of range");
    chk_clamp_low: assert property (@(posedge clk) disable iff (srst) // RL3
        (holdSeconds < HOLD_MIN_S) |-> holdClamped == HOLD_MIN_S)
        else $error("short setting not raised");
    chk_clamp_high: assert property (@(posedge clk) disable iff (srst) // RL3
        (holdSeconds > HOLD_MAX_S) |-> holdClamped == HOLD_MAX_S)
        else $error("long setting not limited");
    // Restart relay
    chk_restart_on_return: assert property (@(posedge clk) disable iff (srst) // RL5
        (phase_r == ST_OUT && lineNow) |=> restartRelayOn)
        else $error("no restart pulse");
    chk_restart_source: assert property (@(posedge clk) disable iff (srst) // RL5
        $rose(restartRelayOn) |-> $past(phase_r) == ST_OUT)
        else $error("restart without power return");
    chk_restart_holds: assert property (@(posedge clk) disable iff (srst) // RL5
        (restartRelayOn && lineNow && !(tick && restartTicks_r == 8'(RESTART_TICKS - 1))) |=> restartRelayOn)
        else $error("restart pulse cut short");
    chk_restart_ends: assert property (@(posedge clk) disable iff (srst) // RL6
        $fell(restartRelayOn) |-> restartTicks_r == 8'h0)
        else $error("restart count bad");
endmodule
`default_nettype wire

// >>> power_interrupt_flash_timer_test.sv
// Purpose: Self-checking bench for the power interruption flash timer
// Assumes: Short outage and tick counts by parameter
// Notes: Checks sit away from tick edges to absorb alignment
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %s exp %b got %b", n, e, g); end end
module power_interrupt_flash_timer_test;
    import power_hold_pkg::*;
    localparam int OC = 50;
    localparam int TK = 10;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic conflictFault = 1'b0;
    logic voltagesOk = 1'b1;
    logic extPresent = 1'b0;
    logic extFault = 1'b0;
    logic [3:0] holdSeconds = HOLD_RST_S;
    wire logic lineOk, faultRelayOn, restartRelayOn, holdActive;
    int miscompares = 0;
    int comparisons = 0;
    always #25 clk = ~clk;
    cabinet_model cab (.clk(clk), .lineOk(lineOk));
    power_interrupt_flash_timer #(.OUTAGE_CYCLES(OC), .TICK_CYCLES(TK)) dut (.clk(clk), .srst(srst),
        .lineOk(lineOk), .holdSeconds(holdSeconds), .conflictFault(conflictFault), .voltagesOk(voltagesOk),
        .extPresent(extPresent), .extFault(extFault), .faultRelayOn(faultRelayOn),
        .restartRelayOn(restartRelayOn), .holdActive(holdActive));
    // Reference model: pin sync as a two-deep queue, timing in plain counts
    logic [1:0] syncQ[$];
    logic [1:0] seen;
    int mPhase = 0;
    int mOut = 0;
    int mHold = 0;
    int mRst = 0;
    int hsClamp = 4;
    logic mRelay = 1'b0;
    logic mRestart = 1'b0;
    always @(posedge clk) begin
        if (srst) begin
            syncQ = '{2'b00, 2'b00};
            mPhase = 0;
            mOut = 0;
            mRelay = 1'b0;
            mRestart = 1'b0;
        end else begin
            seen = syncQ.pop_front();
            syncQ.push_back({lineOk, extPresent & extFault});
            hsClamp = int'(holdSeconds);
            if (holdSeconds < HOLD_MIN_S) begin
                hsClamp = int'(HOLD_MIN_S);
            end else if (holdSeconds > HOLD_MAX_S) begin
                hsClamp = int'(HOLD_MAX_S);
            end
            if (mRestart) begin
                mRst++;
                mRestart = (mRst < RESTART_TICKS * TK);
            end
            if (mPhase == 0) begin
                mOut = seen[1] ? 0 : mOut + 1;
                if (mOut == OC) begin
                    mPhase = 1;
                    mOut = 0;
                end
            end else if (mPhase == 1) begin
                if (seen[1]) begin
                    mPhase = 2;
                    mHold = 0;
                    mRst = 0;
                    mRestart = 1'b1;
                end
            end else if (!seen[1]) begin
                mPhase = 0;
                mRestart = 1'b0;
            end else begin
                mHold++;
                if (mHold >= hsClamp * TICKS_PER_SEC * TK) begin
                    mPhase = 0;
                end
            end
            mRelay = (mPhase == 0) && seen[1] && voltagesOk && !conflictFault && !seen[0];
        end
    end
    always @(negedge clk) begin
        `CHK("model fault", mRelay, faultRelayOn)
        `CHK("model restart", mRestart, restartRelayOn)
        `CHK("model hold", (mPhase != 0), holdActive)
    end
    task automatic results();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Sample on the falling edge, return on a rising edge
    task automatic expect3(input string nm, input int n, input logic f, input logic r, input logic h);
        repeat (n - 1) @(posedge clk);
        @(negedge clk);
        `CHK({nm, " fault"}, f, faultRelayOn)
        `CHK({nm, " restart"}, r, restartRelayOn)
        `CHK({nm, " hold"}, h, holdActive)
        $display("test %s done", nm);
        @(posedge clk);
    endtask
    task automatic longOut(input logic [3:0] hs, input logic healthy);
        int hc;
        hc = ((hs < 4) ? 4 : (hs > 10) ? 10 : int'(hs)) * 10 * TK;
        holdSeconds <= hs;
        cab.power(1'b0, OC + 10);
        expect3("outage", 1, 1'b0, 1'b0, 1'b1);
        cab.power(1'b1, 0);
        expect3("return", 20, 1'b0, 1'b1, 1'b1);
        expect3("restart", 210, 1'b0, 1'b1, 1'b1);
        expect3("restartEnd", 50, 1'b0, 1'b0, 1'b1);
        expect3("holdLate", hc - 310, 1'b0, 1'b0, 1'b1);
        expect3("run", 70, healthy, 1'b0, 1'b0);
    endtask
    initial begin
        void'($urandom(32'h925aa78f));
        expect3("reset", 4, 1'b0, 1'b0, 1'b0);
        srst <= 1'b0;
        expect3("healthy", 6, 1'b1, 1'b0, 1'b0);
        voltagesOk <= 1'b0;
        expect3("lowVolt", 3, 1'b0, 1'b0, 1'b0);
        voltagesOk <= 1'b1;
        extFault <= 1'b1;
        expect3("extUnplugged", 6, 1'b1, 1'b0, 1'b0);
        extFault <= 1'b0;
        extPresent <= 1'b1;
        expect3("extPlugged", 6, 1'b1, 1'b0, 1'b0);
        extFault <= 1'b1;
        expect3("extFault", 6, 1'b0, 1'b0, 1'b0);
        extPresent <= 1'b0;
        extFault <= 1'b0;
        cab.power(1'b0, OC - 10);
        cab.power(1'b1, 5);
        cab.power(1'b0, OC - 10);
        cab.power(1'b1, 0);
        expect3("shortOut", 10, 1'b1, 1'b0, 1'b0);
        longOut(4'h2, 1'b1);
        longOut(4'hF, 1'b1);
        longOut(4'($urandom_range(10, 4)), 1'b1);
        conflictFault <= 1'b1;
        longOut(4'hA, 1'b0);
        conflictFault <= 1'b0;
        expect3("clear", 3, 1'b1, 1'b0, 1'b0);
        results();
    end
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        results();
    end
endmodule
`undef CHK
`default_nettype wire
